// ==== core/mas_add8.sv ====
/*
  adder with carry in, carry out and carry out of the low nibble.
  assumes both operands are WIDTH bits; combinational only.
*/
`default_nettype none

module mas_add8 #(
  parameter int WIDTH = 8
) (
  // operands
  input  wire logic [WIDTH-1:0] a,
  input  wire logic [WIDTH-1:0] b,
  input  wire logic             cin,
  // results
  output logic      [WIDTH-1:0] sum,
  output logic                  carryOut,
  output logic                  digitCarry
);

  logic [WIDTH:0] full;
  logic [4:0]     low;

  initial begin
    if (WIDTH < 5) begin
      $error("mas_add8: WIDTH must be at least 5");
    end
  end

  always_comb begin
    full       = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
    low        = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    sum        = full[WIDTH-1:0];
    carryOut   = full[WIDTH];
    digitCarry = low[4];
  end

endmodule

`default_nettype wire

// ==== core/mas_exec_unit.sv ====
/*
  execution unit for pointer add, and/add with literal or file operand,
  add with carry and arithmetic right shift, behind an AHB-Lite slave.
  assumes one bus master issuing single word transfers; the file operand
  is placed by software (or the core) before the opcode is written.
*/
// Behaviour
// - pointer add sign-extends the 6-bit literal and adds it to the chosen pointer pair.
// - the pointer sum wraps modulo 16 bits and no status flag changes.
// - and with literal puts accumulator AND immediate in the accumulator, only zero flag.
// - add literal puts accumulator plus immediate in the accumulator, sets all three flags.
// - and with file ANDs accumulator and file operand, routed by d, only zero flag.
// - add with file adds accumulator and file operand, routed by d, sets all three flags.
// - destination bit 0 sends the result to the accumulator, 1 back to the file.
// - arithmetic right shift keeps bit 7, shifts 7:1 down, old bit 0 into carry, sets C, Z.
// - add with carry sums accumulator, file operand and carry, routed by d, sets all flags.
// - pointer add decodes from 11 0001 0nkk kkkk and completes in one cycle.
`default_nettype none

module mas_exec_unit
  import mas_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic      [1:0]  hresp,
  // file write-back toward the core
  output logic             fileWrStrobe,
  output logic      [6:0]  fileWrAddr,
  output logic      [7:0]  fileWrData
);

  mas_state_t s_q;
  mas_state_t s_d;

  logic [13:0] opc;
  logic        execOp;
  logic        isPtrAdd;
  logic        isAndLit;
  logic        isAddLit;
  logic        isAndFile;
  logic        isAddFile;
  logic        isShrFile;
  logic        isAddCarry;
  logic        isFileOp;
  logic        destFile;
  logic [7:0]  lit8;
  logic [15:0] litSext;
  logic [7:0]  addB;
  logic        addCin;
  logic [7:0]  addSum;
  logic        addCarry;
  logic        addDigit;
  logic [7:0]  result;

  // opcode is taken straight from the write data phase: one cycle execute
  assign opc      = hwdata[13:0];
  assign execOp   = (s_q.phase == PH_WRITE) && (s_q.addr == OFF_OPCODE);
  assign isPtrAdd = execOp && (opc[13:7] == OPC_PTR_ADD);
  assign isAndLit   = execOp && (opc[13:8] == OPC_AND_LIT);
  assign isAddLit   = execOp && (opc[13:8] == OPC_ADD_LIT);
  assign isAndFile  = execOp && (opc[13:8] == OPC_AND_FILE);
  assign isAddFile  = execOp && (opc[13:8] == OPC_ADD_FILE);
  assign isShrFile  = execOp && (opc[13:8] == OPC_SHR_FILE);
  assign isAddCarry = execOp && (opc[13:8] == OPC_ADD_CARRY);
  assign isFileOp = isAndFile || isAddFile || isShrFile || isAddCarry;
  assign destFile = opc[7];
  assign lit8     = opc[7:0];
  assign litSext  = {{10{opc[5]}}, opc[5:0]};
  assign addB     = isAddLit ? lit8 : s_q.fileOp;
  assign addCin   = isAddCarry ? s_q.status[ST_C] : 1'b0;

  mas_add8 #(
    .WIDTH      (8)
  ) u_add (
    .a          (s_q.accum),
    .b          (addB),
    .cin        (addCin),
    .sum        (addSum),
    .carryOut   (addCarry),
    .digitCarry (addDigit)
  );

  always_comb begin
    s_d          = s_q;
    s_d.wbStrobe = 1'b0;
    result       = 8'h00;
    // register writes from the data phase
    if (s_q.phase == PH_WRITE) begin
      case (s_q.addr)
        OFF_OPCODE:  s_d.opcode = opc;
        OFF_FILE_OP: s_d.fileOp = hwdata[7:0];
        OFF_ACCUM:   s_d.accum  = hwdata[7:0];
        OFF_STATUS:  s_d.status = hwdata[2:0];
        OFF_PTR0:    s_d.ptr0   = hwdata[15:0];
        OFF_PTR1:    s_d.ptr1   = hwdata[15:0];
        default:     s_d.opcode = s_q.opcode;
      endcase
    end
    // pointer add: 16-bit sum wraps, flags untouched
    if (isPtrAdd) begin
      if (opc[6]) begin
        s_d.ptr1 = 16'(s_q.ptr1 + litSext);
      end else begin
        s_d.ptr0 = 16'(s_q.ptr0 + litSext);
      end
    end
    if (isAndLit) begin
      s_d.accum         = s_q.accum & lit8;
      s_d.status[ST_Z]  = (s_d.accum == 8'h00);
    end
    if (isAddLit) begin
      s_d.accum         = addSum;
      s_d.status[ST_C]  = addCarry;
      s_d.status[ST_DIGIT] = addDigit;
      s_d.status[ST_Z]  = (addSum == 8'h00);
    end
    if (isAndFile) begin
      result           = s_q.accum & s_q.fileOp;
      s_d.status[ST_Z] = (result == 8'h00);
    end
    if (isAddFile || isAddCarry) begin
      result            = addSum;
      s_d.status[ST_C]  = addCarry;
      s_d.status[ST_DIGIT] = addDigit;
      s_d.status[ST_Z]  = (addSum == 8'h00);
    end
    if (isShrFile) begin
      result           = {s_q.fileOp[7], s_q.fileOp[7:1]};
      s_d.status[ST_C] = s_q.fileOp[0];
      s_d.status[ST_Z] = (result == 8'h00);
    end
    // destination routing shared by every file operation
    if (isFileOp) begin
      s_d.wbDest = destFile;
      s_d.wbAddr = opc[6:0];
      s_d.wbData = result;
      if (destFile) begin
        s_d.fileOp   = result;
        s_d.wbStrobe = 1'b1;
      end else begin
        s_d.accum    = result;
      end
    end
    // next address phase; hsize ignored, only whole words are served
    if (hready && hsel && htrans[1]) begin
      s_d.phase = hwrite ? PH_WRITE : PH_READ;
      s_d.addr  = haddr[4:0];
    end else begin
      s_d.phase = PH_IDLE;
      s_d.addr  = s_q.addr;
    end
    // read data from the updated state so a write then read sees new value
    s_d.rdata = 32'h0000_0000;
    if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[4:0])
        OFF_OPCODE:  s_d.rdata = {18'h0, s_d.opcode};
        OFF_FILE_OP: s_d.rdata = {24'h0, s_d.fileOp};
        OFF_ACCUM:   s_d.rdata = {24'h0, s_d.accum};
        OFF_STATUS:  s_d.rdata = {29'h0, s_d.status};
        OFF_PTR0:    s_d.rdata = {16'h0, s_d.ptr0};
        OFF_PTR1:    s_d.rdata = {16'h0, s_d.ptr1};
        OFF_WBACK:   s_d.rdata = {15'h0, s_d.wbDest, s_d.wbData,
                                  1'b0, s_d.wbAddr};
        default:     s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q.phase    <= PH_IDLE;
      s_q.addr     <= 5'h00;
      s_q.rdata    <= 32'h0000_0000;
      s_q.opcode   <= RST_OPCODE;
      s_q.accum    <= RST_ACCUM;
      s_q.fileOp   <= RST_FILE_OP;
      s_q.status   <= RST_STATUS;
      s_q.ptr0     <= RST_PTR;
      s_q.ptr1     <= RST_PTR;
      s_q.wbStrobe <= 1'b0;
      s_q.wbDest   <= 1'b0;
      s_q.wbAddr   <= 7'h00;
      s_q.wbData   <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  // zero wait states, so no stall logic is needed
  assign hreadyout    = 1'b1;
  assign hresp        = HRESP_OKAY;
  assign hrdata       = s_q.rdata;
  assign fileWrStrobe = s_q.wbStrobe;
  assign fileWrAddr   = s_q.wbAddr;
  assign fileWrData   = s_q.wbData;

  // helpers read only by the checks below
  logic [7:0] accQ;
  logic [7:0] fopQ;
  logic       carQ;
  logic [7:0] destQ;
  assign accQ  = s_q.accum;
  assign fopQ  = s_q.fileOp;
  assign carQ  = s_q.status[ST_C];
  assign destQ = s_q.wbDest ? s_q.fileOp : s_q.accum;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_wb_pulse;
    fileWrStrobe ##1 !fileWrStrobe;
  endsequence

  property p_ptr_add;
    isPtrAdd && !opc[6] |=>
      (s_q.ptr0 == 16'($past(s_q.ptr0) + $past(litSext))) && $stable(s_q.ptr1);
  endproperty
  a_ptr_add: assert property (p_ptr_add)
    else $error("pointer pair 0 sum wrong");

  property p_ptr_flags;
    isPtrAdd |=> $stable(s_q.status) && $stable(s_q.accum);
  endproperty
  a_ptr_flags: assert property (p_ptr_flags)
    else $error("pointer add touched flags");

  property p_and_lit;
    isAndLit |=> (accQ == ($past(accQ) & $past(lit8))) &&
      $stable(s_q.status[1:0]) && (s_q.status[ST_Z] == (accQ == 8'h00));
  endproperty
  a_and_lit: assert property (p_and_lit)
    else $error("and with literal wrong");

  property p_add_lit;
    isAddLit |=> ({carQ, accQ} == 9'($past(accQ) + $past(lit8)));
  endproperty
  a_add_lit: assert property (p_add_lit)
    else $error("add literal wrong");

  property p_and_file;
    isAndFile |=> (destQ == ($past(accQ) & $past(fopQ))) &&
      $stable(s_q.status[1:0]);
  endproperty
  a_and_file: assert property (p_and_file)
    else $error("and with file wrong");

  property p_add_file_dc;
    isAddFile |=> s_q.status[ST_DIGIT] ==
      (5'($past(accQ[3:0])) + 5'($past(fopQ[3:0])) > 5'h0f);
  endproperty
  a_add_file_dc: assert property (p_add_file_dc)
    else $error("digit carry wrong");

  property p_dest_file;
    isFileOp && destFile |=> s_wb_pulse and $stable(accQ);
  endproperty
  a_dest_file: assert property (p_dest_file)
    else $error("file destination not written back");

  property p_dest_acc;
    isFileOp && !destFile |=> !fileWrStrobe && $stable(fopQ);
  endproperty
  a_dest_acc: assert property (p_dest_acc)
    else $error("accumulator destination wrote file");

  property p_shr_file;
    isShrFile |=> (destQ == {$past(fopQ[7]), $past(fopQ[7:1])}) &&
      (carQ == $past(fopQ[0]));
  endproperty
  a_shr_file: assert property (p_shr_file)
    else $error("arithmetic shift wrong");

  property p_add_carry;
    isAddCarry |=> ({carQ, destQ} ==
      9'($past(accQ) + $past(fopQ) + $past(carQ)));
  endproperty
  a_add_carry: assert property (p_add_carry)
    else $error("add with carry wrong");

  property p_zero;
    (isAddFile || isAddCarry || isShrFile) |=>
      s_q.status[ST_Z] == (destQ == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");

endmodule

`default_nettype wire

// ==== shared/mas_pkg.sv ====
/*
  constants, types and register map of the add and shift execution unit.
  assumes a single 25 MHz clock and word-wide AHB-Lite register access.
*/
`default_nettype none

package mas_pkg;

  // register byte offsets, decoded on the low address bits
  localparam int          ADDR_W       = 5;
  localparam logic [4:0]  OFF_OPCODE   = 5'h00;
  localparam logic [4:0]  OFF_FILE_OP  = 5'h04;
  localparam logic [4:0]  OFF_ACCUM    = 5'h08;
  localparam logic [4:0]  OFF_STATUS   = 5'h0c;
  localparam logic [4:0]  OFF_PTR0     = 5'h10;
  localparam logic [4:0]  OFF_PTR1     = 5'h14;
  localparam logic [4:0]  OFF_WBACK    = 5'h18;

  // status field positions
  localparam int          ST_C         = 0;
  localparam int          ST_DIGIT     = 1;
  localparam int          ST_Z         = 2;

  // write-back register field positions
  localparam int          WB_ADDR_LSB  = 0;
  localparam int          WB_DATA_LSB  = 8;
  localparam int          WB_DEST_BIT  = 16;

  // opcode patterns, matched on the high opcode bits
  localparam logic [6:0]  OPC_PTR_ADD  = 7'h62;
  localparam logic [5:0]  OPC_AND_LIT  = 6'h39;
  localparam logic [5:0]  OPC_ADD_LIT  = 6'h3e;
  localparam logic [5:0]  OPC_AND_FILE = 6'h05;
  localparam logic [5:0]  OPC_ADD_FILE = 6'h07;
  localparam logic [5:0]  OPC_SHR_FILE = 6'h37;
  localparam logic [5:0]  OPC_ADD_CARRY = 6'h3d;
  localparam int          OPC_W        = 14;
  localparam int          PTR_LIT_W    = 6;

  // values after reset
  localparam logic [7:0]  RST_ACCUM    = 8'h00;
  localparam logic [7:0]  RST_FILE_OP  = 8'h00;
  localparam logic [15:0] RST_PTR      = 16'h0000;
  localparam logic [2:0]  RST_STATUS   = 3'h0;
  localparam logic [13:0] RST_OPCODE   = 14'h0000;

  // bus constants
  localparam logic [1:0]  HRESP_OKAY   = 2'h0;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ  = 2'b11
  } mas_phase_t;

  typedef struct packed {
    mas_phase_t  phase;
    logic [4:0]  addr;
    logic [31:0] rdata;
    logic [13:0] opcode;
    logic [7:0]  accum;
    logic [7:0]  fileOp;
    logic [2:0]  status;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic        wbStrobe;
    logic        wbDest;
    logic [6:0]  wbAddr;
    logic [7:0]  wbData;
  } mas_state_t;

endpackage

`default_nettype wire

// ==== tb/mas_exec_unit_tb.sv ====
/*
  self-checking bench for the add and shift execution unit.
  assumes the unit is the only AHB-Lite slave, zero wait states allowed.
*/
`default_nettype none

module mas_exec_unit_tb
  import mas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys;
  logic        rst;
  logic        hsel;
  logic        hwrite;
  logic        hready;
  logic        hreadyout;
  logic        fileWrStrobe;
  logic [1:0]  htrans;
  logic [1:0]  hresp;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [6:0]  fileWrAddr;
  logic [7:0]  fileWrData;
  int          error_cnt;
  int          cmp_count;

  // single slave: its ready is the bus ready
  assign hready = hreadyout;

  mas_exec_unit dut_u (
    .clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
    .hwdata, .hrdata, .hreadyout, .hresp,
    .fileWrStrobe, .fileWrAddr, .fileWrData
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // bounded wait; a hung slave counts as a mismatch
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk_sys);
    end
    if (n >= 16) begin
      error_cnt++;
      $display("BAD %0t bus stall", $time);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    htrans <= 2'h2;
    haddr  <= {27'h0, a};
    hwrite <= wr;
    hsel   <= 1'b1;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    wait_rdy();
    q = hrdata;
    chk({30'h0, hresp}, {30'h0, HRESP_OKAY}, "hresp");
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e,
                        input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e, what);
  endtask

  // expected {status, result} worked out from the flag rules
  function automatic logic [10:0] model(input logic [13:0] opc,
    input logic [7:0] a, f, input logic [2:0] st);
    logic [7:0] b, r;
    logic [8:0] s;
    logic [4:0] n;
    logic       ci;
    logic       lit;
    logic [2:0] o;
    o   = st;
    lit = opc[13:8] == OPC_AND_LIT || opc[13:8] == OPC_ADD_LIT;
    ci  = (opc[13:8] == OPC_ADD_CARRY) ? st[ST_C] : 1'b0;
    b   = lit ? opc[7:0] : f;
    s   = {1'b0, a} + {1'b0, b} + {8'h0, ci};
    n   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    r   = s[7:0];
    if (opc[13:8] == OPC_AND_LIT || opc[13:8] == OPC_AND_FILE) begin
      r = a & b;
    end else if (opc[13:8] == OPC_SHR_FILE) begin
      r = {f[7], f[7:1]};
      o[ST_C] = f[0];
    end else begin
      o[ST_C]  = s[8];
      o[ST_DIGIT] = n[4];
    end
    o[ST_Z] = r == 8'h00;
    return {o, r};
  endfunction

  task automatic run_op(input logic [13:0] opc, input logic [7:0] a, f,
                        input logic [2:0] st);
    logic [10:0] e;
    logic        d;
    logic        s0;
    logic        s1;
    logic        lit;
    e = model(opc, a, f, st);
    lit = opc[13:8] == OPC_AND_LIT || opc[13:8] == OPC_ADD_LIT;
    d = opc[7] && !lit;
    wr(OFF_ACCUM, {24'h0, a});
    wr(OFF_FILE_OP, {24'h0, f});
    wr(OFF_STATUS, {29'h0, st});
    wr(OFF_OPCODE, {18'h0, opc});
    #1 s0 = fileWrStrobe;
    @(posedge clk_sys);
    #1 s1 = fileWrStrobe;
    // one-cycle strobe only when the result goes back to the file
    chk({30'h0, s0 & s1, s0 | s1}, {30'h0, 1'b0, d}, "strobe");
    if (d) begin
      chk({17'h0, fileWrAddr, fileWrData}, {17'h0, opc[6:0], e[7:0]},
          "file link");
    end
    @(posedge clk_sys);
    rd_chk(OFF_ACCUM, {24'h0, d ? a : e[7:0]}, "accum");
    rd_chk(OFF_FILE_OP, {24'h0, d ? e[7:0] : f}, "file");
    rd_chk(OFF_STATUS, {29'h0, e[10:8]}, "flags");
    rd_chk(OFF_OPCODE, {18'h0, opc}, "opcode");
    if (!lit) begin
      rd_chk(OFF_WBACK, {15'h0, opc[7], e[7:0], 1'b0, opc[6:0]},
             "wback");
    end
  endtask

  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rd_chk(5'(i * 4), 32'h0, "reset value");
    end
    wr(5'h1c, 32'hffff_ffff);
    rd_chk(5'h1c, 32'h0, "unmapped");
  endtask

  task automatic ptr_case(input logic n, input logic [5:0] k,
                          input logic [15:0] init, exp);
    wr(n ? OFF_PTR1 : OFF_PTR0, {16'h0, init});
    wr(n ? OFF_PTR0 : OFF_PTR1, 32'h5a5a);
    wr(OFF_STATUS, 32'h5);
    wr(OFF_OPCODE, {18'h0, OPC_PTR_ADD, n, k});
    rd_chk(n ? OFF_PTR1 : OFF_PTR0, {16'h0, exp}, "ptr sum");
    rd_chk(n ? OFF_PTR0 : OFF_PTR1, 32'h5a5a, "other ptr");
    rd_chk(OFF_STATUS, 32'h5, "ptr flags");
  endtask

  task automatic t_ptr();
    ptr_case(1'b0, 6'h05, 16'hfffe, 16'h0003);
    ptr_case(1'b1, 6'h20, 16'h0001, 16'hffe1);
    ptr_case(1'b0, 6'h1f, 16'h1234, 16'h1253);
    ptr_case(1'b1, 6'h3f, 16'h0000, 16'hffff);
  endtask

  task automatic t_lit();
    run_op({OPC_AND_LIT, 8'ha5}, 8'h5a, 8'h33, 3'h3);
    run_op({OPC_AND_LIT, 8'hff}, 8'h80, 8'h33, 3'h4);
    run_op({OPC_ADD_LIT, 8'h79}, 8'h88, 8'h33, 3'h0);
    run_op({OPC_ADD_LIT, 8'h01}, 8'hff, 8'h33, 3'h0);
    run_op({OPC_ADD_LIT, 8'h01}, 8'h0f, 8'h33, 3'h1);
  endtask

  task automatic t_file();
    run_op({OPC_AND_FILE, 1'b0, 7'h7f}, 8'hf0, 8'h3c, 3'h3);
    run_op({OPC_AND_FILE, 1'b1, 7'h00}, 8'h0f, 8'hf0, 3'h0);
    run_op({OPC_ADD_FILE, 1'b0, 7'h15}, 8'h90, 8'h70, 3'h0);
    run_op({OPC_ADD_FILE, 1'b1, 7'h6a}, 8'h0e, 8'h02, 3'h7);
  endtask

  task automatic t_shift();
    run_op({OPC_SHR_FILE, 1'b0, 7'h21}, 8'h11, 8'h81, 3'h2);
    run_op({OPC_SHR_FILE, 1'b1, 7'h42}, 8'h11, 8'h02, 3'h1);
    run_op({OPC_SHR_FILE, 1'b0, 7'h7f}, 8'h11, 8'h01, 3'h0);
  endtask

  task automatic t_carry();
    run_op({OPC_ADD_CARRY, 1'b0, 7'h33}, 8'h7f, 8'h80, 3'h1);
    run_op({OPC_ADD_CARRY, 1'b1, 7'h44}, 8'h08, 8'h08, 3'h0);
    run_op({OPC_ADD_CARRY, 1'b1, 7'h01}, 8'hff, 8'hff, 3'h1);
  endtask

  // watchdog: the run needs a few hundred cycles
  initial begin
    #400000;
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_ptr();
    t_lit();
    t_file();
    t_shift();
    t_carry();
    end_of_test();
  end
endmodule

`default_nettype wire
